// [common/e1nb_pkg.sv]
// Package with register map, field positions and timing constants for the E1 national bit block.
package e1nb_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_TX_ALIGN = 8'h20;
    localparam logic [7:0] ADDR_TX_NONALIGN = 8'h21;
    localparam logic [7:0] ADDR_RX_ALIGN = 8'h28;
    localparam logic [7:0] ADDR_RX_NONALIGN = 8'h29;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ==========================================================
    // Field positions
    localparam int SI_BIT = 7;
    localparam int NFAS_BIT = 6;
    localparam int ALARM_BIT = 5;
    localparam int SA_MSB = 4;
    localparam int TCR_SA_LO = 3;
    localparam int TCR_SA_HI = 7;
    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 50;
    localparam int HOST_WINDOW_US = 250;
    localparam int HOST_WINDOW_CYC = HOST_WINDOW_US * CLK_MHZ;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Host register port request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } e1nb_req_t;

    // Overrides from other framer features.
    typedef struct packed {
        logic si_from_serial;
        logic crc4_mode;
        logic auto_ebit;
        logic [7:0] transmit_control_register;
    } e1nb_ovr_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ALIGN = 2'b01,
        ST_NONALIGN = 2'b11
    } e1nb_state_t;
endpackage : e1nb_pkg

// [rtl/e1nb_byte_reg.sv]
// Two-byte storage with registered read data for the overhead bytes.
`timescale 1ns/100ps
module e1nb_byte_reg (
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [7:0] wd_align,
    input wire logic [7:0] wd_nonalign,
    output logic [7:0] rd_align,
    output logic [7:0] rd_nonalign
);
    import e1nb_pkg::*;
    logic [7:0] a_d;
    logic [7:0] n_d;

    always_comb
    begin
        a_d = rd_align;
        n_d = rd_nonalign;
        if (we)
        begin
            a_d = wd_align;
            n_d = wd_nonalign;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_align <= REG_RESET;
            rd_nonalign <= REG_RESET;
        end
        else
        begin
            rd_align <= a_d;
            rd_nonalign <= n_d;
        end
    end
endmodule : e1nb_byte_reg

// [rtl/e1nb_national_bits.sv]
// Timeslot-0 overhead byte access: receive capture and transmit insertion.
`timescale 1ns/100ps
module e1nb_national_bits (
    input wire logic clk,
    input wire logic rst,
    input wire e1nb_pkg::e1nb_req_t host_req,
    output logic [7:0] host_rdata,
    input wire e1nb_pkg::e1nb_ovr_t ovr,
    input wire logic rx_ts0_valid,
    input wire logic rx_ts0_bit,
    input wire logic rx_ts0_last,
    input wire logic rx_frame_is_align,
    input wire logic tx_ts0_req,
    input wire logic tx_ovr_bit,
    output logic tx_ts0_bit,
    output logic tx_ts0_is_align,
    output logic rx_align_flag,
    output logic tx_align_flag
);
    import e1nb_pkg::*;

    // ==========================================================
    // Host writable transmit bytes
    logic [7:0] tx_align_frame_byte_q, tx_align_frame_byte_d;
    logic [7:0] tx_nonalign_frame_byte_q, tx_nonalign_frame_byte_d;
    logic [7:0] rx_align_frame_byte;
    logic [7:0] rx_nonalign_frame_byte;
    logic [7:0] host_rdata_d;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    always_comb
    begin
        tx_align_frame_byte_d = tx_align_frame_byte_q;
        tx_nonalign_frame_byte_d = tx_nonalign_frame_byte_q;
        host_rdata_d = host_rdata;
        if (host_req.wr && hit(host_req.addr, ADDR_TX_ALIGN))
            tx_align_frame_byte_d = host_req.wdata;
        if (host_req.wr && hit(host_req.addr, ADDR_TX_NONALIGN))
            tx_nonalign_frame_byte_d = host_req.wdata;
        if (host_req.rd)
        begin
            case (host_req.addr)
                ADDR_TX_ALIGN: host_rdata_d = tx_align_frame_byte_q;
                ADDR_TX_NONALIGN: host_rdata_d = tx_nonalign_frame_byte_q;
                ADDR_RX_ALIGN: host_rdata_d = rx_align_frame_byte;
                ADDR_RX_NONALIGN: host_rdata_d = rx_nonalign_frame_byte;
                default: host_rdata_d = REG_RESET;
            endcase
        end
    end

    // ==========================================================
    // Receive capture
    // Bits shift in MSB first, so the finished byte already has Si in bit 7.
    logic [7:0] rx_shift_q, rx_shift_d;
    logic rx_align_done_q, rx_align_done_d;
    logic [7:0] rx_hold_align_q, rx_hold_align_d;
    logic rx_we;
    logic rx_align_flag_d;

    always_comb
    begin
        rx_shift_d = rx_shift_q;
        rx_align_done_d = rx_align_done_q;
        rx_hold_align_d = rx_hold_align_q;
        rx_we = 1'b0;
        rx_align_flag_d = 1'b0;
        if (rx_ts0_valid)
        begin
            rx_shift_d = {rx_shift_q[6:0], rx_ts0_bit};
            if (rx_ts0_last && rx_frame_is_align)
            begin
                rx_hold_align_d = {rx_shift_q[6:0], rx_ts0_bit};
                rx_align_done_d = 1'b1;
            end
            else if (rx_ts0_last && rx_align_done_q)
            begin
                // Both bytes are committed together with the flag.
                rx_we = 1'b1;
                rx_align_flag_d = 1'b1;
                rx_align_done_d = 1'b0;
            end
        end
    end

    e1nb_byte_reg u_rx_store (
        .clk(clk),
        .rst(rst),
        .we(rx_we),
        .wd_align(rx_hold_align_q),
        .wd_nonalign(rx_shift_d),
        .rd_align(rx_align_frame_byte),
        .rd_nonalign(rx_nonalign_frame_byte)
    );

    // ==========================================================
    // Transmit insertion
    // A frame pair starts with the align byte; sampling happens only at its start,
    // so a late host write waits for the next pair and old data is resent.
    e1nb_state_t st_q, st_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] smp_align_q, smp_align_d;
    logic [7:0] smp_nonalign_q, smp_nonalign_d;
    logic tx_ts0_bit_d;
    logic tx_is_align_d;
    logic tx_align_flag_d;
    logic [7:0] cur;
    logic si_ovr;
    logic sa_ovr;

    assign si_ovr = ovr.si_from_serial | ovr.crc4_mode | ovr.auto_ebit;
    assign sa_ovr = |ovr.transmit_control_register[TCR_SA_HI:TCR_SA_LO];

    always_comb
    begin
        st_d = st_q;
        bit_d = bit_q;
        smp_align_d = smp_align_q;
        smp_nonalign_d = smp_nonalign_q;
        tx_ts0_bit_d = tx_ts0_bit;
        tx_is_align_d = tx_ts0_is_align;
        tx_align_flag_d = 1'b0;
        cur = (st_q == ST_NONALIGN) ? smp_nonalign_q : smp_align_q;
        if (tx_ts0_req)
        begin
            if (st_q == ST_IDLE || (st_q == ST_NONALIGN && bit_q == BIT_LAST))
            begin
                smp_align_d = tx_align_frame_byte_q;
                smp_nonalign_d = tx_nonalign_frame_byte_q;
                tx_align_flag_d = 1'b1;
                cur = tx_align_frame_byte_q;
                st_d = ST_ALIGN;
                bit_d = 3'h0;
            end
            else if (bit_q == BIT_LAST)
            begin
                st_d = ST_NONALIGN;
                cur = smp_nonalign_q;
                bit_d = 3'h0;
            end
            else
                bit_d = bit_q + 3'h1;
            tx_is_align_d = (st_d == ST_ALIGN);
            // MSB first, Si at bit 7 and Sa bits at 4..0.
            tx_ts0_bit_d = cur[3'(SI_BIT) - bit_d];
            if (bit_d == 3'h0 && si_ovr)
                tx_ts0_bit_d = tx_ovr_bit;
            if (st_d == ST_NONALIGN && bit_d >= 3'(SI_BIT - SA_MSB) && sa_ovr)
                tx_ts0_bit_d = tx_ovr_bit;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tx_align_frame_byte_q <= REG_RESET;
            tx_nonalign_frame_byte_q <= REG_RESET;
            host_rdata <= REG_RESET;
            rx_shift_q <= REG_RESET;
            rx_align_done_q <= 1'b0;
            rx_hold_align_q <= REG_RESET;
            rx_align_flag <= 1'b0;
            st_q <= ST_IDLE;
            bit_q <= 3'h0;
            smp_align_q <= REG_RESET;
            smp_nonalign_q <= REG_RESET;
            tx_ts0_bit <= 1'b0;
            tx_ts0_is_align <= 1'b0;
            tx_align_flag <= 1'b0;
        end
        else
        begin
            tx_align_frame_byte_q <= tx_align_frame_byte_d;
            tx_nonalign_frame_byte_q <= tx_nonalign_frame_byte_d;
            host_rdata <= host_rdata_d;
            rx_shift_q <= rx_shift_d;
            rx_align_done_q <= rx_align_done_d;
            rx_hold_align_q <= rx_hold_align_d;
            rx_align_flag <= rx_align_flag_d;
            st_q <= st_d;
            bit_q <= bit_d;
            smp_align_q <= smp_align_d;
            smp_nonalign_q <= smp_nonalign_d;
            tx_ts0_bit <= tx_ts0_bit_d;
            tx_ts0_is_align <= tx_is_align_d;
            tx_align_flag <= tx_align_flag_d;
        end
    end

    // ==========================================================
    // Checks
    AST_RX_FLAG_UPDATE: assert property (@(posedge clk) disable iff (rst)
        rx_align_flag |-> rx_nonalign_frame_byte == $past(rx_shift_d))
        else $error("Receive bytes not updated with flag.");
    AST_RX_HOLD: assert property (@(posedge clk) disable iff (rst)
        !rx_align_flag |-> $stable(rx_align_frame_byte))
        else $error("Receive byte changed without flag.");
    AST_TX_SAMPLE: assert property (@(posedge clk) disable iff (rst)
        tx_align_flag |-> smp_align_q == $past(tx_align_frame_byte_q))
        else $error("Transmit byte not sampled at flag.");
    AST_TX_KEEP: assert property (@(posedge clk) disable iff (rst)
        !tx_align_flag |-> $stable(smp_nonalign_q))
        else $error("Sampled transmit byte changed between flags.");
    AST_SA_OVR: assert property (@(posedge clk) disable iff (rst)
        (tx_ts0_req && sa_ovr && st_d == ST_NONALIGN && bit_d >= 3'h3) |=>
        tx_ts0_bit == $past(tx_ovr_bit))
        else $error("Sa bit not overridden.");
    AST_SI_OVR: assert property (@(posedge clk) disable iff (rst)
        (tx_ts0_req && si_ovr && bit_d == 3'h0) |=> tx_ts0_bit == $past(tx_ovr_bit))
        else $error("Si bit not overridden.");
    AST_ALARM: assert property (@(posedge clk) disable iff (rst)
        (tx_ts0_req && st_d == ST_NONALIGN && bit_d == 3'h2) |=>
        tx_ts0_bit == $past(smp_nonalign_q[ALARM_BIT]))
        else $error("Alarm bit not sent from nonalign byte.");
    AST_ALT: assert property (@(posedge clk) disable iff (rst)
        (tx_ts0_req && st_q == ST_ALIGN && bit_q == BIT_LAST) |=> !tx_ts0_is_align)
        else $error("Frames do not alternate.");
endmodule : e1nb_national_bits

// [testbench/e1nb_line_model.sv]
// Framer-side model that feeds received timeslot-0 bits to the block.
`timescale 1ns/100ps
module e1nb_line_model (
    input wire logic clk,
    output logic rx_ts0_valid,
    output logic rx_ts0_bit,
    output logic rx_ts0_last,
    output logic rx_frame_is_align
);
    initial
    begin
        rx_ts0_valid = 1'b0;
        rx_ts0_bit = 1'b0;
        rx_ts0_last = 1'b0;
        rx_frame_is_align = 1'b0;
    end
    // ==========================================================
    // Frame pair, or a lone nonalign frame when with_a is low.
    task automatic send(input logic [7:0] a, input logic [7:0] n, input logic with_a);
        logic [15:0] w;
        w = {a, n};
        for (int i = with_a ? 0 : 8; i < 16; i++)
        begin
            @(posedge clk);
            rx_ts0_valid <= 1'b1;
            rx_ts0_bit <= w[15 - i];
            rx_ts0_last <= (i % 8) == 7;
            rx_frame_is_align <= i < 8;
        end
        @(posedge clk);
        rx_ts0_valid <= 1'b0;
        rx_ts0_last <= 1'b0;
        // A stale bit must not pass for data, so the line shows the inverse.
        rx_ts0_bit <= ~w[0];
    endtask : send
endmodule : e1nb_line_model

// [testbench/e1nb_national_bits_tb.sv]
// Self-checking testbench for the timeslot-0 overhead byte block.
`timescale 1ns/100ps
module e1nb_national_bits_tb;
    import e1nb_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    e1nb_req_t host_req = '0;
    e1nb_ovr_t ovr = '0;
    logic tx_ts0_req = 1'b0;
    logic tx_ovr_bit = 1'b1;
    logic [7:0] host_rdata;
    logic rx_v, rx_b, rx_l, rx_a, tx_bit, tx_al, rx_flag, tx_flag;
    logic [15:0] d;
    logic [15:0] g, al;
    logic f;
    int fails = 0;
    int cmp_count = 0;

    e1nb_national_bits i_e1nb_national_bits (.clk(clk), .rst(rst), .host_req(host_req),
        .host_rdata(host_rdata), .ovr(ovr), .rx_ts0_valid(rx_v), .rx_ts0_bit(rx_b),
        .rx_ts0_last(rx_l), .rx_frame_is_align(rx_a), .tx_ts0_req(tx_ts0_req),
        .tx_ovr_bit(tx_ovr_bit), .tx_ts0_bit(tx_bit), .tx_ts0_is_align(tx_al),
        .rx_align_flag(rx_flag), .tx_align_flag(tx_flag));
    e1nb_line_model i_e1nb_line_model (.clk(clk), .rx_ts0_valid(rx_v), .rx_ts0_bit(rx_b),
        .rx_ts0_last(rx_l), .rx_frame_is_align(rx_a));

    initial
    begin
        forever #10 clk = ~clk;
    end
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        host_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk);
        host_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        host_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        host_req.rd <= 1'b0;
        #1 v = {8'h00, host_rdata};
    endtask : rd
    // One align and one nonalign frame of transmit bits.
    task automatic pair();
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk);
            tx_ts0_req <= 1'b1;
            @(posedge clk);
            tx_ts0_req <= 1'b0;
            #1 g[15 - i] = tx_bit;
            al[15 - i] = tx_al;
            if (i == 0)
                f = tx_flag;
        end
    endtask : pair
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] addrs [5] = '{8'h20, 8'h21, 8'h28, 8'h29, 8'h33};
        foreach (addrs[i])
        begin
            rd(addrs[i], d);
            chk(d, 16'h0000);
        end
    endtask : t_reset
    task automatic t_rx();
        i_e1nb_line_model.send(8'h9b, 8'h5a, 1'b1);
        // The flag is launched by the edge at which the model returns, so look after it settles.
        #1 chk({15'h0000, rx_flag}, 16'h0001);
        @(posedge clk);
        #1 chk({15'h0000, rx_flag}, 16'h0000);
        rd(8'h28, d);
        chk(d, 16'h009b);
        rd(8'h29, d);
        chk(d, 16'h005a);
        wr(8'h28, 8'h00);
        rd(8'h28, d);
        chk(d, 16'h009b);
        i_e1nb_line_model.send(8'h00, 8'hff, 1'b0);
        #1 chk({15'h0000, rx_flag}, 16'h0000);
        rd(8'h29, d);
        chk(d, 16'h005a);
    endtask : t_rx
    task automatic t_tx();
        wr(8'h20, 8'h1b);
        wr(8'h21, 8'h60);
        rd(8'h20, d);
        chk(d, 16'h001b);
        rd(8'h21, d);
        chk(d, 16'h0060);
        pair();
        chk({15'h0000, f}, 16'h0001);
        chk(g, 16'h1b60);
        chk(al, 16'hff00);
        wr(8'h21, 8'h7f);
        pair();
        chk(g, 16'h1b7f);
        // A write landing after the pair has sampled must not reach this pair.
        fork
            pair();
            begin
                repeat (4) @(posedge clk);
                wr(8'h21, 8'h55);
            end
        join
        chk(g, 16'h1b7f);
        pair();
        chk(g, 16'h1b55);
    endtask : t_tx
    task automatic t_ovr();
        wr(8'h20, 8'h1b);
        wr(8'h21, 8'h40);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            ovr.si_from_serial <= i == 0;
            ovr.crc4_mode <= i == 1;
            ovr.auto_ebit <= i == 2;
            ovr.transmit_control_register <= (i > 2) ? (8'h01 << i) : 8'h00;
            pair();
            chk(g, (i < 3) ? 16'h9bc0 : 16'h1b5f);
        end
        ovr <= '0;
    endtask : t_ovr
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_rx();
        t_tx();
        t_ovr();
        test_done();
    end
    // A hang is cut short and reported as a failure.
    initial
    begin
        #200000;
        fails++;
        test_done();
    end
endmodule : e1nb_national_bits_tb
